// ---- src/tres_pkg.sv ----
// package: timing constants, sequence encodings and carrier types for the rail sequencer
package tres_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 25000000;
  localparam int DELAY_MS_DEFAULT = 10;
  localparam int REFRESH_US = 400;
  localparam int GAP_MS = 120;
  localparam int DELAY_CYCLES = (DELAY_MS_DEFAULT * (CLOCK_HZ / 1000));
  localparam int REFRESH_CYCLES = (REFRESH_US * (CLOCK_HZ / 1000000));
  localparam int GAP_CYCLES = (GAP_MS * (CLOCK_HZ / 1000));
  localparam int TIMER_WIDTH = 24;

  // ----------------------------------------------------------------
  // power-down order selections
  // ----------------------------------------------------------------
  localparam logic [2:0] ORDER_321 = 3'h1;
  localparam logic [2:0] ORDER_312 = 3'h2;
  localparam logic [2:0] ORDER_231 = 3'h3;
  localparam logic [2:0] ORDER_213 = 3'h4;
  localparam logic [2:0] ORDER_132 = 3'h5;
  localparam logic [2:0] ORDER_123 = 3'h6;
  localparam logic [2:0] ORDER_DEFAULT = ORDER_321;

  // reset value of the rail hold pattern: all rails pulled low
  localparam logic [2:0] HOLD_RESET = 3'h7;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic first_rail_output;
    logic second_rail_output;
    logic third_rail_output;
  } tres_rails_type;

  typedef struct packed {
    logic [1:0] step0;
    logic [1:0] step1;
    logic [1:0] step2;
  } tres_order_type;

  // rail indices 0..2 for each power-down step
  function automatic tres_order_type tres_order_decode(input logic [2:0] sel);
    tres_order_type o;
    o = '{2'h2, 2'h1, 2'h0};
    case (sel)
      ORDER_312: o = '{2'h2, 2'h0, 2'h1};
      ORDER_231: o = '{2'h1, 2'h2, 2'h0};
      ORDER_213: o = '{2'h1, 2'h0, 2'h2};
      ORDER_132: o = '{2'h0, 2'h2, 2'h1};
      ORDER_123: o = '{2'h0, 2'h1, 2'h2};
      default: o = '{2'h2, 2'h1, 2'h0};
    endcase
    return o;
  endfunction

endpackage

// ---- src/tres_timer.sv ----
// down-counting delay timer shared by every sequencing step
`timescale 1ns/1ps
module tres_timer #(
  parameter int WIDTH = tres_pkg::TIMER_WIDTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic clear,
  input wire logic [WIDTH-1:0] count,
  // status
  output logic running,
  output logic expired
);

  logic [WIDTH-1:0] remain;
  wire last_tick = running && (remain == {{(WIDTH-1){1'b0}}, 1'b1});

  // one master counter so all delays keep the same ratio
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      remain <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= last_tick && !clear && !load;
      if (clear) begin
        remain <= '0;
        running <= 1'b0;
      end else if (load) begin
        remain <= count;
        running <= 1'b1;
      end else if (running) begin
        remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        running <= !last_tick;
      end
    end
  end

endmodule

// ---- src/tres_sequencer.sv ----
// three-rail enable sequencer: enable input to three open-drain rail enables
`timescale 1ns/1ps
module tres_sequencer #(
  parameter int WIDTH = tres_pkg::TIMER_WIDTH,
  parameter logic [WIDTH-1:0] UP1_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] UP2_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] UP3_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] DN1_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] DN2_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] DN3_CYCLES = WIDTH'(tres_pkg::DELAY_CYCLES),
  parameter logic [WIDTH-1:0] REFRESH_CYCLES = WIDTH'(tres_pkg::REFRESH_CYCLES),
  parameter logic [WIDTH-1:0] GAP_CYCLES = WIDTH'(tres_pkg::GAP_CYCLES),
  parameter logic [2:0] DOWN_ORDER = tres_pkg::ORDER_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // enable comparator result, asynchronous to clock
  input wire logic enable_level,
  // open-drain rail enables, index 0 is the first rail
  input wire logic [2:0] rail_in,
  output logic [2:0] rail_out,
  output logic [2:0] rail_oe
);

  typedef enum {
    IDLE, UP_WAIT1, UP_WAIT2, UP_WAIT3, UP_DONE, GAP_DOWN,
    DN_WAIT1, DN_WAIT2, DN_WAIT3, GAP_UP
  } tres_state_type;

  tres_state_type state, next_state;
  logic enable_meta, enable_sync, enable_prev;
  logic [2:0] hold, next_hold;
  logic pending, next_pending;
  logic timer_load, timer_clear;
  logic [WIDTH-1:0] timer_count;
  logic timer_running, timer_expired;
  tres_pkg::tres_rails_type rails_view;

  // ----------------------------------------------------------------
  // enable synchroniser
  // ----------------------------------------------------------------
  // comparator output is a pin, so two flops before use
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      enable_meta <= 1'b0;
      enable_sync <= 1'b0;
      enable_prev <= 1'b0;
    end else begin
      enable_meta <= enable_level;
      enable_sync <= enable_meta;
      enable_prev <= enable_sync;
    end
  end

  wire enable_rise = enable_sync && !enable_prev;
  wire enable_fall = !enable_sync && enable_prev;
  localparam tres_pkg::tres_order_type ORDER = tres_pkg::tres_order_decode(DOWN_ORDER);

  // ----------------------------------------------------------------
  // sequencing decisions
  // ----------------------------------------------------------------
  // a single reloadable timer covers all six steps; only one runs at a time
  always_comb begin
    next_state = state;
    next_hold = hold;
    next_pending = pending;
    timer_load = 1'b0;
    timer_clear = 1'b0;
    timer_count = UP1_CYCLES + REFRESH_CYCLES;
    case (state)
      IDLE: begin
        if (enable_rise) begin
          next_state = UP_WAIT1;
          timer_load = 1'b1;
          timer_count = UP1_CYCLES + REFRESH_CYCLES;
        end
      end
      UP_WAIT1: begin
        if (!enable_sync) begin
          next_state = IDLE;
          timer_clear = 1'b1;
        end else if (timer_expired) begin
          next_hold[0] = 1'b0;
          next_state = UP_WAIT2;
          timer_load = 1'b1;
          timer_count = UP2_CYCLES;
        end
      end
      UP_WAIT2, UP_WAIT3: begin
        if (enable_fall && !pending) begin
          next_pending = 1'b1;
          timer_load = 1'b1;
          timer_count = (state == UP_WAIT2) ? UP2_CYCLES : UP3_CYCLES;
        end else if (timer_expired) begin
          if (state == UP_WAIT2) begin
            next_hold[1] = 1'b0;
            next_state = UP_WAIT3;
            timer_load = 1'b1;
            timer_count = UP3_CYCLES;
          end else begin
            next_hold[2] = 1'b0;
            next_state = pending ? GAP_DOWN : UP_DONE;
            next_pending = 1'b0;
            timer_load = pending;
            timer_count = GAP_CYCLES;
          end
        end
      end
      UP_DONE: begin
        if (!enable_sync) begin
          next_state = DN_WAIT1;
          timer_load = 1'b1;
          timer_count = DN1_CYCLES + REFRESH_CYCLES;
        end
      end
      GAP_DOWN: begin
        if (timer_expired) begin
          next_state = enable_sync ? UP_DONE : DN_WAIT1;
          timer_load = !enable_sync;
          timer_count = DN1_CYCLES + REFRESH_CYCLES;
        end
      end
      DN_WAIT1: begin
        if (enable_sync) begin
          next_state = UP_DONE;
          timer_clear = 1'b1;
        end else if (timer_expired) begin
          next_hold[ORDER.step0] = 1'b1;
          next_state = DN_WAIT2;
          timer_load = 1'b1;
          timer_count = DN2_CYCLES;
        end
      end
      DN_WAIT2, DN_WAIT3: begin
        if (enable_rise && !pending) begin
          next_pending = 1'b1;
          timer_load = 1'b1;
          timer_count = (state == DN_WAIT2) ? DN2_CYCLES : DN3_CYCLES;
        end else if (timer_expired) begin
          if (state == DN_WAIT2) begin
            next_hold[ORDER.step1] = 1'b1;
            next_state = DN_WAIT3;
            timer_load = 1'b1;
            timer_count = DN3_CYCLES;
          end else begin
            next_hold[ORDER.step2] = 1'b1;
            next_state = pending ? GAP_UP : IDLE;
            next_pending = 1'b0;
            timer_load = pending;
            timer_count = GAP_CYCLES;
          end
        end
      end
      GAP_UP: begin
        if (timer_expired) begin
          next_state = enable_sync ? UP_WAIT1 : IDLE;
          timer_load = enable_sync;
          timer_count = UP1_CYCLES + REFRESH_CYCLES;
        end
      end
      default: begin
        next_state = IDLE;
        next_hold = tres_pkg::HOLD_RESET;
      end
    endcase
  end

  // state and hold pattern
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= IDLE;
      hold <= tres_pkg::HOLD_RESET;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      hold <= next_hold;
      pending <= next_pending;
    end
  end

  // output flops: drive low while held, release otherwise
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rail_out <= 3'h0;
      rail_oe <= tres_pkg::HOLD_RESET;
    end else begin
      rail_out <= 3'h0;
      rail_oe <= next_hold;
    end
  end

  // readback of pulled-up pins kept for debug visibility only
  assign rails_view = tres_pkg::tres_rails_type'({rail_in[0], rail_in[1], rail_in[2]});

  // one down-counter on the master clock times every step
  tres_timer #(
    .WIDTH(WIDTH)
  ) u_timer (
    .clock(clock),
    .reset(reset),
    .load(timer_load),
    .clear(timer_clear),
    .count(timer_count),
    .running(timer_running),
    .expired(timer_expired)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_held_a: assert property (@(posedge clock) disable iff (reset)
    (state == IDLE) |-> (rail_oe == 3'h7))
    else $error("rails not held in idle");

  early_drop_a: assert property (@(posedge clock) disable iff (reset)
    (state == UP_WAIT1 && !enable_sync) |=> (state == IDLE && !timer_running))
    else $error("early enable drop did not reset");

  up_order_a: assert property (@(posedge clock) disable iff (reset)
    (state == UP_WAIT1 || state == UP_WAIT2 || state == UP_WAIT3) |->
    ((rail_oe[1] || !rail_oe[0]) && (rail_oe[2] || !rail_oe[1])))
    else $error("power-up order broken");

  down_start_a: assert property (@(posedge clock) disable iff (reset)
    (state == UP_DONE && !enable_sync) |=> (state == DN_WAIT1 && timer_running))
    else $error("power-down did not start");

  down_first_a: assert property (@(posedge clock) disable iff (reset)
    (state == DN_WAIT1 && timer_expired && !enable_sync) |=> ##1 rail_oe[ORDER.step0])
    else $error("wrong first rail in power-down");

  up_finish_a: assert property (@(posedge clock) disable iff (reset)
    (pending && state == UP_WAIT3 && timer_expired) |=> (state == GAP_DOWN))
    else $error("interrupted power-up not completed");

  gap_hold_a: assert property (@(posedge clock) disable iff (reset)
    (state == GAP_DOWN) |-> (rail_oe == 3'h0))
    else $error("rail dropped during gap");

  dn_finish_a: assert property (@(posedge clock) disable iff (reset)
    (pending && state == DN_WAIT3 && timer_expired) |=> (state == GAP_UP))
    else $error("interrupted power-down not completed");

  gap_low_a: assert property (@(posedge clock) disable iff (reset)
    (state == GAP_UP) |-> (rail_oe == 3'h7))
    else $error("rail released during gap");

  open_drain_a: assert property (@(posedge clock) disable iff (reset)
    rail_out == 3'h0)
    else $error("rail driven high");

endmodule

// ---- verification/tres_regulator_model.sv ----
// regulator enable inputs: pull-ups on the open-drain rails and a start-order monitor
`timescale 1ns/1ps
module tres_regulator_model (
  // clock
  input wire logic clock,
  // rail pins from the sequencer
  input wire logic [2:0] rail_out,
  input wire logic [2:0] rail_oe,
  // wire levels and monitor result
  output logic [2:0] rail_in,
  output logic order_fault
);
  // the pull-up wins wherever the sequencer lets go of the pin
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rail_in[i] = rail_oe[i] ? rail_out[i] : 1'b1;
    end
  end
  // a regulator must never run while the one it depends on is held off
  initial order_fault = 1'b0;
  always @(posedge clock) begin
    if (rail_in[1] && !rail_in[0]) order_fault <= 1'b1;
    if (rail_in[2] && !rail_in[1]) order_fault <= 1'b1;
  end
endmodule

// ---- verification/tb.sv ----
// testbench: rail sequencer power-up, power-down, glitch and interrupted sequences
`timescale 1ns/1ps
module tb;
  // short delays keep the run small; every window is derived from them
  localparam int U1 = 20;
  localparam int U2 = 24;
  localparam int U3 = 28;
  localparam int D1 = 22;
  localparam int D2 = 26;
  localparam int D3 = 30;
  localparam int RF = 5;
  localparam int GP = 30;
  typedef struct {logic en; logic [2:0] pat; int lo; int hi;} tres_row_type;
  logic clock;
  logic reset;
  logic enable_level;
  logic [2:0] rail_in;
  logic [2:0] rail_out;
  logic [2:0] rail_oe;
  logic order_fault;
  int errors;
  int checks;
  int cnt;
  tres_row_type rows [6];

  // distinct delays so a swapped timer shows up as a wrong step time
  tres_sequencer #(
    .UP1_CYCLES(24'(U1)), .UP2_CYCLES(24'(U2)), .UP3_CYCLES(24'(U3)),
    .DN1_CYCLES(24'(D1)), .DN2_CYCLES(24'(D2)), .DN3_CYCLES(24'(D3)),
    .REFRESH_CYCLES(24'(RF)), .GAP_CYCLES(24'(GP))
  ) u_tres_sequencer (
    .clock(clock), .reset(reset), .enable_level(enable_level),
    .rail_in(rail_in), .rail_out(rail_out), .rail_oe(rail_oe)
  );
  tres_regulator_model u_tres_regulator_model (
    .clock(clock), .rail_out(rail_out), .rail_oe(rail_oe), .rail_in(rail_in), .order_fault(order_fault)
  );

  // one clock for everything
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // inputs always move 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // wait for a rail pattern, then judge how many cycles it took
  task automatic wait_oe(input logic [2:0] pat, input int lo, input int hi);
    cnt = 0;
    while (rail_oe !== pat && cnt <= hi) begin
      tick(1);
      cnt++;
    end
    check("rail_oe", pat, rail_oe);
    check("rail_in", ~pat, rail_in);
    check("rail_out", 3'h0, rail_out);
    checks++;
    if (cnt < lo || cnt > hi) begin
      errors++;
      $display("wrong value step time expected %0d to %0d seen %0d", lo, hi, cnt);
    end
  endtask

  task automatic hold(input logic [2:0] pat, input int n);
    repeat (n) begin
      tick(1);
      check("rail_oe held", pat, rail_oe);
    end
  endtask

  task automatic play(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      enable_level = rows[i].en;
      wait_oe(rows[i].pat, rows[i].lo, rows[i].hi);
    end
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    checks = 0;
    enable_level = 1'b0;
    reset = 1'b1;
    rows = '{'{1'b1, 3'h6, U1 + RF + 1, U1 + RF + 12}, '{1'b1, 3'h4, U2, U2 + 6}, '{1'b1, 3'h0, U3, U3 + 6},
             '{1'b0, 3'h4, D1 + RF + 1, D1 + RF + 12}, '{1'b0, 3'h6, D2, D2 + 6}, '{1'b0, 3'h7, D3, D3 + 6}};
    tick(9);
    check("rail_oe in reset", 3'h7, rail_oe);
    tick(1);
    reset = 1'b0;
    hold(3'h7, 20);
    // plain power-up then power-down, refresh added to the first step of each
    play(0, 5);
    // enable glitch before the first release: nothing may move
    enable_level = 1'b1;
    tick(U1 / 2);
    enable_level = 1'b0;
    hold(3'h7, U1 + RF + 20);
    // power-up cut short after the first release
    play(0, 0);
    enable_level = 1'b0;
    wait_oe(3'h4, U2, U2 + 10);
    wait_oe(3'h0, U3, U3 + 6);
    hold(3'h0, GP - 4);
    wait_oe(3'h4, D1 + RF + 4, D1 + RF + 16);
    play(4, 5);
    // power-down cut short after its first step
    play(0, 3);
    enable_level = 1'b1;
    wait_oe(3'h6, D2, D2 + 10);
    wait_oe(3'h7, D3, D3 + 6);
    hold(3'h7, GP - 4);
    wait_oe(3'h6, U1 + RF + 4, U1 + RF + 16);
    play(1, 2);
    // enable back high before the first power-down step: rails stay released
    enable_level = 1'b0;
    tick(8);
    enable_level = 1'b1;
    hold(3'h0, D1 + RF + 20);
    // reset in mid-run pulls every rail low again
    reset = 1'b1;
    tick(1);
    check("rail_oe after reset", 3'h7, rail_oe);
    reset = 1'b0;
    hold(3'h7, 10);
    check("order_fault", 3'h0, {2'h0, order_fault});
    wrap_up();
  end
endmodule
